// [hw/sesr_status_reg.sv]
// external/status read register bank with AHB-Lite slave
// assumes receiver and transmitter status inputs synchronous to hclk
`timescale 1ns/1ns
`default_nettype none
module sesr_status_reg (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_abort_seq,
   input wire logic rx_break_seq,
   input wire logic rx_char_avail,
   input wire logic zero_count,
   input wire logic tx_buf_empty,
   input wire logic sync_hunt,
   input wire logic dcd_level,
   input wire logic cts_level,
   input wire logic tx_underrun,
   output logic ext_status_irq,
   output logic rx_null_push
);
   typedef struct packed {
      sesr_pkg::sesr_phase_e phase;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic [7:0] en;
      logic [1:0] ctl;
      logic ip;
      logic brk;
      logic und;
      logic sync;
      logic dcd;
      logic txe;
      logic zc;
      logic rxa;
      logic null_push;
   } sesr_state_s;
   sesr_state_s s_ff, nxt_s;
   logic cts_bit;
   logic cts_raise;
   logic take;
   logic wr_now;
   logic [2:0] cmd;
   logic async_mode;
   logic brk_seq;
   logic other_raise;
   logic [7:0] status_v;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = a == off;
   endfunction

   sesr_cts_latch u_cts (
      .hclk(hclk),
      .hresetn(hresetn),
      .cts_level(cts_level),
      .enable(s_ff.en[sesr_pkg::EN_CTS]),
      .pending(s_ff.ip),
      .clear_evt(cmd == sesr_pkg::CMD_RESET_EXT),
      .snap(other_raise),
      .cts_bit(cts_bit),
      .raise(cts_raise)
   );

   assign status_v = {s_ff.brk, s_ff.und, cts_bit, s_ff.sync,
                      s_ff.dcd, s_ff.txe, s_ff.zc, s_ff.rxa};
   assign take = hsel && hready && htrans == sesr_pkg::HTRANS_NONSEQ
                 && hsize == sesr_pkg::HSIZE_WORD;
   assign wr_now = s_ff.phase == sesr_pkg::PH_WRITE;
   assign cmd = (wr_now && hit(s_ff.wr_addr, sesr_pkg::OFF_COMMAND))
                ? hwdata[sesr_pkg::CMD_LSB +: 3] : sesr_pkg::CMD_NULL;
   assign async_mode = s_ff.ctl[sesr_pkg::CTL_ASYNC];
   // receiver status selected by framing mode
   assign brk_seq = async_mode ? rx_break_seq : rx_abort_seq;

   always_comb begin
      logic brk_raise;
      logic und_raise;
      logic misc_raise;
      brk_raise = 1'b0;
      und_raise = 1'b0;
      misc_raise = 1'b0;
      nxt_s = s_ff;
      nxt_s.null_push = 1'b0;
      nxt_s.phase = sesr_pkg::PH_IDLE;
      // bus: the read word is caught at the address phase so it stays put
      if (take) begin
         if (hwrite) begin
            nxt_s.phase = sesr_pkg::PH_WRITE;
            nxt_s.wr_addr = haddr[7:0];
         end else if (hit(haddr[7:0], sesr_pkg::OFF_STATUS)) begin
            nxt_s.rdata = {24'h000000, status_v};
         end else if (hit(haddr[7:0], sesr_pkg::OFF_ENABLE)) begin
            nxt_s.rdata = {24'h000000, s_ff.en};
         end else if (hit(haddr[7:0], sesr_pkg::OFF_CONTROL)) begin
            nxt_s.rdata = {30'h0, s_ff.ctl};
         end else if (hit(haddr[7:0], sesr_pkg::OFF_PENDING)) begin
            nxt_s.rdata = {31'h0, s_ff.ip};
         end else begin
            nxt_s.rdata = 32'h00000000;
         end
      end
      if (wr_now && hit(s_ff.wr_addr, sesr_pkg::OFF_ENABLE)) begin
         nxt_s.en = hwdata[7:0];
      end
      if (wr_now && hit(s_ff.wr_addr, sesr_pkg::OFF_CONTROL)) begin
         nxt_s.ctl = hwdata[1:0];
      end
      // break/abort follows the line sequence with no command needed
      nxt_s.brk = brk_seq;
      if (s_ff.brk != nxt_s.brk && s_ff.en[sesr_pkg::EN_BRK]) begin
         brk_raise = 1'b1;
      end
      if (async_mode && s_ff.brk && !nxt_s.brk) begin
         nxt_s.null_push = 1'b1;
      end
      // underrun latch: a set in the same cycle as the clear wins
      if (cmd == sesr_pkg::CMD_CLR_UNDERRUN) begin
         nxt_s.und = 1'b0;
      end
      if (tx_underrun || cmd == sesr_pkg::CMD_SEND_ABORT
          || !s_ff.ctl[sesr_pkg::CTL_TXEN]) begin
         nxt_s.und = 1'b1;
      end
      if (!s_ff.und && nxt_s.und && s_ff.en[sesr_pkg::EN_UND]) begin
         und_raise = 1'b1;
      end
      nxt_s.sync = sync_hunt;
      nxt_s.dcd = dcd_level;
      nxt_s.txe = tx_buf_empty;
      nxt_s.zc = zero_count;
      nxt_s.rxa = rx_char_avail;
      if ((s_ff.sync != sync_hunt && s_ff.en[sesr_pkg::EN_SYNC])
          || (s_ff.dcd != dcd_level && s_ff.en[sesr_pkg::EN_DCD])
          || (zero_count && !s_ff.zc && s_ff.en[sesr_pkg::EN_ZC])) begin
         misc_raise = 1'b1;
      end
      other_raise = brk_raise || und_raise || misc_raise;
      // pending flag: a new event beats the reset command
      if (cmd == sesr_pkg::CMD_RESET_EXT) begin
         nxt_s.ip = 1'b0;
      end
      if (other_raise || cts_raise) begin
         nxt_s.ip = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '0;
         s_ff.en <= sesr_pkg::ENABLE_RST;
         s_ff.ctl <= sesr_pkg::CONTROL_RST;
         s_ff.und <= sesr_pkg::STATUS_UND_RST;
         s_ff.txe <= sesr_pkg::STATUS_TXE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign hrdata = s_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ext_status_irq = s_ff.ip;
   assign rx_null_push = s_ff.null_push;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_freeze;
      take && !hwrite && hit(haddr[7:0], sesr_pkg::OFF_STATUS)
         |=> hrdata[7:0] == $past(status_v);
   endproperty
   a_freeze: assert property (p_freeze) else $error("status read not frozen");

   property p_width;
      take && !hwrite && hit(haddr[7:0], sesr_pkg::OFF_STATUS) |=> hrdata[31:8] == 24'h000000;
   endproperty
   a_width: assert property (p_width) else $error("status upper bits not zero");

   property p_abort_set;
      !async_mode && rx_abort_seq |=> s_ff.brk;
   endproperty
   a_abort_set: assert property (p_abort_set) else $error("abort not reported");

   property p_brk_end;
      !brk_seq ##1 !brk_seq |-> !s_ff.brk;
   endproperty
   a_brk_end: assert property (p_brk_end) else $error("bit 7 did not clear");

   property p_brk_irq;
      $changed(s_ff.brk) && $past(s_ff.en[sesr_pkg::EN_BRK]) |-> s_ff.ip;
   endproperty
   a_brk_irq: assert property (p_brk_irq) else $error("break edge gave no interrupt");

   property p_break_set;
      async_mode && rx_break_seq |=> s_ff.brk;
   endproperty
   a_break_set: assert property (p_break_set) else $error("break not reported");

   property p_null_once;
      rx_null_push |-> $past(async_mode) && $fell(s_ff.brk) ##1 !rx_null_push;
   endproperty
   a_null_once: assert property (p_null_once) else $error("null push not single");

   property p_abort_cmd;
      cmd == sesr_pkg::CMD_SEND_ABORT |=> s_ff.und;
   endproperty
   a_abort_cmd: assert property (p_abort_cmd) else $error("abort command left bit 6 low");

   property p_und_clear;
      $fell(s_ff.und) |-> $past(cmd) == sesr_pkg::CMD_CLR_UNDERRUN;
   endproperty
   a_und_clear: assert property (p_und_clear) else $error("bit 6 cleared without command");

   property p_und_irq;
      $rose(s_ff.und) && $past(s_ff.en[sesr_pkg::EN_UND]) |-> s_ff.ip;
   endproperty
   a_und_irq: assert property (p_und_irq) else $error("underrun gave no interrupt");

   property p_cts_live;
      !s_ff.en[sesr_pkg::EN_CTS] ##1 !s_ff.en[sesr_pkg::EN_CTS] |-> cts_bit == $past(cts_level);
   endproperty
   a_cts_live: assert property (p_cts_live) else $error("bit 5 not live");

   property p_rdata_hold;
      !(take && !hwrite) |=> $stable(hrdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

   property p_live_bits;
      hresetn |=> s_ff.txe == $past(tx_buf_empty) && s_ff.rxa == $past(rx_char_avail)
         && s_ff.zc == $past(zero_count);
   endproperty
   a_live_bits: assert property (p_live_bits) else $error("fifo status bits not following");

   property p_null_async;
      async_mode && s_ff.brk && !brk_seq |=> rx_null_push;
   endproperty
   a_null_async: assert property (p_null_async) else $error("break end left no null");

   property p_txdis;
      !s_ff.ctl[sesr_pkg::CTL_TXEN] |=> s_ff.und;
   endproperty
   a_txdis: assert property (p_txdis) else $error("bit 6 low with transmitter off");

   property p_und_clr;
      cmd == sesr_pkg::CMD_CLR_UNDERRUN && s_ff.ctl[sesr_pkg::CTL_TXEN] && !tx_underrun
         |=> !s_ff.und;
   endproperty
   a_und_clr: assert property (p_und_clr) else $error("clear command left bit 6 set");

   property p_und_set;
      tx_underrun |=> s_ff.und;
   endproperty
   a_und_set: assert property (p_und_set) else $error("underrun did not set bit 6");

   // every other source held still, so only the falling bit 6 could raise here
   property p_und_quiet;
      !s_ff.ip && s_ff.und && cmd == sesr_pkg::CMD_CLR_UNDERRUN
         && s_ff.ctl[sesr_pkg::CTL_TXEN] && !tx_underrun && !cts_raise
         && brk_seq == s_ff.brk && sync_hunt == s_ff.sync && dcd_level == s_ff.dcd
         && !(zero_count && !s_ff.zc) |=> !s_ff.ip;
   endproperty
   a_und_quiet: assert property (p_und_quiet) else $error("falling bit 6 raised pending");

   property p_cts_hold;
      s_ff.en[sesr_pkg::EN_CTS] && s_ff.ip && cmd != sesr_pkg::CMD_RESET_EXT && !other_raise
         |=> $stable(cts_bit);
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("bit 5 moved while pending");

   // last pin level is not tracked during reset, so skip the first cycle after it
   property p_cts_raise;
      $past(hresetn) && s_ff.en[sesr_pkg::EN_CTS] && !s_ff.ip && $changed(cts_level)
         |=> cts_bit == $past(cts_level) ##1 s_ff.ip;
   endproperty
   a_cts_raise: assert property (p_cts_raise) else $error("pin edge not latched or raised");

   property p_pend_hold;
      s_ff.ip && cmd != sesr_pkg::CMD_RESET_EXT |=> s_ff.ip;
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending dropped without command");

   property p_enable_rst;
      $rose(hresetn) |-> s_ff.en == sesr_pkg::ENABLE_RST;
   endproperty
   a_enable_rst: assert property (p_enable_rst) else $error("enable reset value wrong");

   property p_status_rst;
      $rose(hresetn) |-> s_ff.und && s_ff.txe && !s_ff.zc && !s_ff.rxa;
   endproperty
   a_status_rst: assert property (p_status_rst) else $error("status reset value wrong");

   c_break: cover property ($fell(s_ff.brk) && async_mode);
   c_underrun: cover property ($rose(s_ff.und) ##[1:20] $fell(s_ff.und));
   c_cts_pend: cover property (s_ff.ip && cts_raise);
   c_cts_odd: cover property (cmd == sesr_pkg::CMD_RESET_EXT && s_ff.ip ##1 cts_raise);
endmodule
`default_nettype wire

// [hw/sesr_pkg.sv]
// constants for the serial external/status read register bank
// assumes a 32-bit AHB-Lite register bus and one system clock
package sesr_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_ENABLE = 8'h04;
   localparam logic [7:0] OFF_COMMAND = 8'h08;
   localparam logic [7:0] OFF_CONTROL = 8'h0C;
   localparam logic [7:0] OFF_PENDING = 8'h10;
   // status bit positions
   localparam int ST_BRK = 7;
   localparam int ST_UND = 6;
   localparam int ST_CTS = 5;
   localparam int ST_SYNC = 4;
   localparam int ST_DCD = 3;
   localparam int ST_TXE = 2;
   localparam int ST_ZC = 1;
   localparam int ST_RXA = 0;
   // enable register bit positions and reset
   localparam int EN_BRK = 7;
   localparam int EN_UND = 6;
   localparam int EN_CTS = 5;
   localparam int EN_SYNC = 4;
   localparam int EN_DCD = 3;
   localparam int EN_ZC = 1;
   localparam logic [7:0] ENABLE_RST = 8'hF8;
   // command field and codes
   localparam int CMD_LSB = 3;
   localparam logic [2:0] CMD_NULL = 3'h0;
   localparam logic [2:0] CMD_SEND_ABORT = 3'h1;
   localparam logic [2:0] CMD_RESET_EXT = 3'h2;
   localparam logic [2:0] CMD_CLR_UNDERRUN = 3'h3;
   // control register
   localparam int CTL_ASYNC = 0;
   localparam int CTL_TXEN = 1;
   localparam logic [1:0] CONTROL_RST = 2'h0;
   // status flop reset values, then AHB-Lite encodings and the bus phase type
   localparam logic STATUS_TXE_RST = 1'b1;
   localparam logic STATUS_UND_RST = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic {PH_IDLE, PH_WRITE} sesr_phase_e;
endpackage

// [hw/sesr_cts_latch.sv]
// clear-to-send latch with odd-transition tracking while an interrupt pends
// assumes cts_level already synchronous to hclk
`timescale 1ns/1ns
`default_nettype none
module sesr_cts_latch (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cts_level,
   input wire logic enable,
   input wire logic pending,
   input wire logic clear_evt,
   input wire logic snap,
   output logic cts_bit,
   output logic raise
);
   typedef struct packed {
      logic latch;
      logic last_pin;
      logic odd;
      logic raise;
   } sesr_cts_s;
   sesr_cts_s s_ff, nxt_s;
   logic pin_chg;
   logic odd_now;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.raise = 1'b0;
      nxt_s.last_pin = cts_level;
      pin_chg = cts_level != s_ff.last_pin;
      odd_now = s_ff.odd ^ pin_chg;
      if (!enable) begin
         nxt_s.latch = cts_level;
         nxt_s.odd = 1'b0;
      end else if (!pending) begin
         nxt_s.odd = 1'b0;
         if (pin_chg || snap) begin
            nxt_s.latch = cts_level;
            nxt_s.raise = pin_chg;
         end
      end else begin
         nxt_s.odd = odd_now;
         // an even count leaves the pin where it was latched, so nothing new to report
         if (clear_evt) begin
            nxt_s.odd = 1'b0;
            nxt_s.latch = cts_level;
            nxt_s.raise = odd_now;
         end else if (snap) begin
            nxt_s.latch = cts_level;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cts_bit = s_ff.latch;
   assign raise = s_ff.raise;
endmodule
`default_nettype wire

// [verif/sesr_line_model.sv]
// line-side model: remote station levels and transmitter underrun strobe
// assumes every task call lands just after a rising hclk edge
`timescale 1ns/1ns
`default_nettype none
module sesr_line_model (
   input wire logic hclk,
   output logic rx_abort_seq,
   output logic rx_break_seq,
   output logic cts_level,
   output logic tx_underrun,
   output logic rx_char_avail,
   output logic zero_count,
   output logic tx_buf_empty,
   output logic sync_hunt,
   output logic dcd_level
);
   // quiet line, empty transmit buffer
   initial begin
      {rx_abort_seq, rx_break_seq, cts_level, tx_underrun} = 4'h0;
      {rx_char_avail, zero_count, sync_hunt, dcd_level} = 4'h0;
      tx_buf_empty = 1'b1;
   end
   // 0 abort sequence, 1 break sequence, else clear-to-send pin
   task automatic line_set(input int k, input logic v);
      case (k)
         0: rx_abort_seq <= v;
         1: rx_break_seq <= v;
         default: cts_level <= v;
      endcase
   endtask
   // strobe lasts one cycle, as the transmitter gives it
   task automatic underrun();
      tx_underrun <= 1'b1;
      @(posedge hclk);
      tx_underrun <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [verif/test_serial_ext_status_read_reg.sv]
// self-checking bench for the external/status read register bank
// assumes sesr_line_model on the line side and one AHB-Lite master here
`timescale 1ns/1ns
`default_nettype none
module test_serial_ext_status_read_reg;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, ext_status_irq, rx_null_push;
   logic rx_abort_seq, rx_break_seq, cts_level, tx_underrun;
   logic rx_char_avail, zero_count, tx_buf_empty, sync_hunt, dcd_level;
   logic [31:0] q;
   int err_count = 0;
   int checks = 0;
   int nulls = 0;

   sesr_status_reg dut (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rx_abort_seq(rx_abort_seq),
      .rx_break_seq(rx_break_seq),
      .rx_char_avail(rx_char_avail),
      .zero_count(zero_count),
      .tx_buf_empty(tx_buf_empty),
      .sync_hunt(sync_hunt),
      .dcd_level(dcd_level),
      .cts_level(cts_level),
      .tx_underrun(tx_underrun),
      .ext_status_irq(ext_status_irq),
      .rx_null_push(rx_null_push)
   );
   sesr_line_model line (
      .hclk(hclk),
      .rx_abort_seq(rx_abort_seq),
      .rx_break_seq(rx_break_seq),
      .cts_level(cts_level),
      .tx_underrun(tx_underrun),
      .rx_char_avail(rx_char_avail),
      .zero_count(zero_count),
      .tx_buf_empty(tx_buf_empty),
      .sync_hunt(sync_hunt),
      .dcd_level(dcd_level)
   );

   initial forever #20 hclk = ~hclk;
   // host side takes each leftover null off the receiver and drops it
   always @(posedge hclk) if (rx_null_push === 1'b1) nulls <= nulls + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   // idle gap first so earlier line events have settled into the status
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      repeat (3) @(posedge hclk);
      hsel <= 1'b1;
      htrans <= sesr_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= sesr_pkg::HSIZE_WORD;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic rd_st(input logic [31:0] e);
      rd(sesr_pkg::OFF_STATUS, e);
   endtask
   task automatic rd_pe(input logic [31:0] e);
      rd(sesr_pkg::OFF_PENDING, e);
      chk({31'h0, ext_status_irq}, e);
   endtask
   task automatic ctl(input logic [31:0] d);
      bus(1'b1, sesr_pkg::OFF_CONTROL, d);
   endtask
   task automatic cmd(input logic [2:0] c);
      bus(1'b1, sesr_pkg::OFF_COMMAND, {26'h0, c, 3'h0});
   endtask
   task automatic clr_pend();
      cmd(sesr_pkg::CMD_RESET_EXT);
      rd_pe(32'h0);
   endtask
   task automatic done(input string n);
      $display("test %s finished, %0d mismatches so far", n, err_count);
   endtask

   task automatic t_reset();
      rd_st(32'h44);
      rd(sesr_pkg::OFF_ENABLE, 32'hF8);
      bus(1'b1, sesr_pkg::OFF_STATUS, 32'hFF);
      rd_st(32'h44);
      rd(8'h20, 32'h0);
      done("reset");
   endtask
   task automatic t_abort();
      clr_pend();
      line.line_set(0, 1'b1);
      rd_st(32'hC4);
      rd_pe(32'h1);
      clr_pend();
      line.line_set(0, 1'b0);
      rd_st(32'h44);
      rd_pe(32'h1);
      done("abort");
   endtask
   task automatic t_break();
      // transmitter on: while it is off bit 6 is held set and the clear cannot take
      ctl(32'h3);
      clr_pend();
      line.line_set(1, 1'b1);
      rd_st(32'hC4);
      line.line_set(1, 1'b0);
      rd_st(32'h44);
      chk(nulls, 32'h1);
      clr_pend();
      cmd(sesr_pkg::CMD_CLR_UNDERRUN);
      rd_st(32'h04);
      cmd(sesr_pkg::CMD_SEND_ABORT);
      rd_st(32'h44);
      rd_pe(32'h1);
      ctl(32'h0);
      done("break");
   endtask
   task automatic t_underrun();
      ctl(32'h2);
      clr_pend();
      cmd(sesr_pkg::CMD_CLR_UNDERRUN);
      rd_st(32'h04);
      rd_pe(32'h0);
      line.underrun();
      rd_st(32'h44);
      rd_pe(32'h1);
      cmd(sesr_pkg::CMD_CLR_UNDERRUN);
      ctl(32'h0);
      rd_st(32'h44);
      done("underrun");
   endtask
   task automatic t_cts();
      clr_pend();
      line.line_set(2, 1'b1);
      rd_st(32'h64);
      rd_pe(32'h1);
      line.line_set(2, 1'b0);
      rd_st(32'h64);
      cmd(sesr_pkg::CMD_RESET_EXT);
      rd_pe(32'h1);
      bus(1'b1, sesr_pkg::OFF_ENABLE, 32'hD8);
      rd_st(32'h44);
      line.line_set(2, 1'b1);
      rd_st(32'h64);
      // pin falls in the address phase: bit 5 drops at the address edge, read keeps old word
      fork
         rd_st(32'h64);
         begin
            repeat (3) @(posedge hclk);
            line.line_set(2, 1'b0);
         end
      join
      rd_st(32'h44);
      done("cts");
   endtask

   task automatic final_report();
      $display("%0d checks, %0d mismatches", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_abort();
      t_break();
      t_underrun();
      t_cts();
      final_report();
   end
   // whole run needs well under 1000 cycles
   initial begin
      repeat (4000) @(posedge hclk);
      err_count++;
      final_report();
   end
endmodule
`default_nettype wire
